// >>> shared/uimc_map.svh
// Purpose: Offsets, field positions, reset values and counts of the interrupt and modem control block.
// Assumes: Included by bare name from the design files.
// Notes:   Offsets select one register in a group of eight byte-wide registers.
`ifndef UIMC_MAP_SVH
`define UIMC_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets.
`define UIMC_OFS_DATA      3'h0
`define UIMC_OFS_IEM       3'h1
`define UIMC_OFS_ISC       3'h2
`define UIMC_OFS_MCO       3'h4
`define UIMC_OFS_LINE      3'h5
`define UIMC_OFS_MSR       3'h6

////////////////////////////////////////////////////////////////////////////////
// Field positions.
`define UIMC_IEM_RDA       0
`define UIMC_IEM_THRE      1
`define UIMC_IEM_RLS       2
`define UIMC_IEM_MSI       3
`define UIMC_MCO_DTR       0
`define UIMC_MCO_RTS       1
`define UIMC_MCO_AUX1      2
`define UIMC_MCO_AUX2      3
`define UIMC_MCO_LOOP      4

////////////////////////////////////////////////////////////////////////////////
// Reset values, counts and shared pin function selects.
`define UIMC_IEM_RESET     4'h0
`define UIMC_MCO_RESET     5'h00
`define UIMC_TIMEOUT_CHARS 3'h4
`define UIMC_MF_AUX2       2'h0
`define UIMC_MF_BAUD       2'h1
`define UIMC_MF_RXREQ      2'h2

`endif

// >>> shared/uimc_pkg.sv
// Purpose: Types shared by the interrupt and modem control block.
// Assumes: Nothing.
// Notes:   Code values are the identification register's low nibble.
package uimc_pkg;

	typedef enum logic [3:0] {
		CODE_NONE  = 4'h1,
		CODE_RLS   = 4'h6,
		CODE_RDA   = 4'h4,
		CODE_TMO   = 4'hc,
		CODE_THRE  = 4'h2,
		CODE_MODEM = 4'h0
	} uimc_code_t;

	typedef struct packed {
		logic carrier;
		logic ring;
		logic dsr;
		logic cts;
	} uimc_modem_t;

endpackage

// >>> design/uimc_sync2.sv
// Purpose: Two flip-flop synchroniser for the pins of the block.
// Assumes: Inputs are asynchronous to mclk.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/100ps

module uimc_sync2 (
	input  wire logic       mclk,   // System clock.
	input  wire logic       rst,    // Asynchronous reset.
	input  wire logic [4:0] async,  // Raw pin levels.
	output logic      [4:0] sync    // Synchronised levels.
);

	logic [4:0] meta;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta <= 5'h1f;
			sync <= 5'h1f;
		end else begin
			meta <= async;
			sync <= meta;
		end
	end

endmodule

// >>> design/uimc_timeout.sv
// Purpose: Character timeout detector of the receive buffer.
// Assumes: char_tick is a one-cycle pulse per character time.
// Notes:   Any activity or an empty buffer restarts the count.
`timescale 1ns/100ps
`include "uimc_map.svh"

module uimc_timeout (
	input  wire logic mclk,      // System clock.
	input  wire logic rst,       // Asynchronous reset.
	input  wire logic enable,    // Buffered mode in effect.
	input  wire logic not_empty, // Receive buffer holds a character.
	input  wire logic activity,  // Character added or removed.
	input  wire logic char_tick, // One character time elapsed.
	output logic      timeout    // Timeout indication.
);

	logic [2:0] count;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			count <= 3'h0;
		end else if (!enable || !not_empty || activity) begin
			count <= 3'h0;
		end else if (char_tick && count != `UIMC_TIMEOUT_CHARS) begin
			count <= count + 3'h1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			timeout <= 1'b0;
		end else begin
			timeout <= enable && not_empty && !activity && count == `UIMC_TIMEOUT_CHARS;
		end
	end

endmodule

// >>> design/uimc_core.sv
// Purpose: Interrupt prioritisation, enable gating and modem control outputs of one serial channel.
// Assumes: Receiver, transmitter and buffer status arrive as same-clock levels and pulses.
// Notes:   Reads of offsets that other blocks own return zero from this block.
`timescale 1ns/100ps
`include "uimc_map.svh"

module uimc_core import uimc_pkg::*; (
	input  wire logic       mclk,                 // System clock, 25 MHz.
	input  wire logic       rst,                  // Asynchronous reset, active high.
	input  wire logic [2:0] addr,                 // Register offset.
	input  wire logic [7:0] wdata,                // Write data.
	input  wire logic       wr,                   // Write strobe.
	input  wire logic       rd,                   // Read strobe.
	output logic      [7:0] rdata,                // Read data, cycle after rd.
	input  wire logic       buffered_mode_enable, // Buffer enable bit.
	input  wire logic       rx_error_event,       // Pulse: overrun, parity, framing or break.
	input  wire logic       rx_data_avail,        // Level: data ready or trigger reached.
	input  wire logic       rx_not_empty,         // Level: receive buffer holds data.
	input  wire logic       rx_fill_change,       // Pulse: character added to receive buffer.
	input  wire logic       char_time_tick,       // Pulse: one character time.
	input  wire logic       tx_holding_empty,     // Level: transmit holding empty.
	input  wire logic       tx_shift_out,         // Transmit shift register output.
	input  wire logic       serial_rx_pin,        // Serial input pin.
	input  wire logic       clear_send_n,         // Modem clear-to-send pin.
	input  wire logic       data_set_ready_n,     // Modem data-set-ready pin.
	input  wire logic       ring_in_n,            // Modem ring pin.
	input  wire logic       carrier_detect_in_n,  // Modem carrier pin.
	input  wire logic [1:0] mf_select,            // Shared pin function select.
	input  wire logic       baud_clock_out,       // Baud clock from the generator.
	input  wire logic       rx_dma_request_n,     // Receive-ready request level.
	output logic            irq_out,              // Interrupt output, active high.
	output logic            serial_tx_pin,        // Serial output pin.
	output logic            rx_shift_in,          // Receive shift register input.
	output logic            terminal_ready_n,     // Terminal-ready pin.
	output logic            request_send_n,       // Request-to-send pin.
	output logic            aux2_pin_n            // Shared aux, baud, receive-ready pin.
);

	////////////////////////////////////////////////////////////////////////////
	// Decoding.

	function automatic logic hit(input logic strobe, input logic [2:0] a, input logic [2:0] ofs);
		hit = strobe && (a == ofs);
	endfunction

	logic       wr_iem;
	logic       wr_mco;
	logic       wr_thr;
	logic       rd_isc;
	logic       rd_line;
	logic       rd_msr;
	logic       rd_rbr;

	assign wr_iem = hit(wr, addr, `UIMC_OFS_IEM);
	assign wr_mco = hit(wr, addr, `UIMC_OFS_MCO);
	assign wr_thr = hit(wr, addr, `UIMC_OFS_DATA);
	assign rd_isc = hit(rd, addr, `UIMC_OFS_ISC);
	assign rd_line = hit(rd, addr, `UIMC_OFS_LINE);
	assign rd_msr = hit(rd, addr, `UIMC_OFS_MSR);
	assign rd_rbr = hit(rd, addr, `UIMC_OFS_DATA);

	////////////////////////////////////////////////////////////////////////////
	// Software registers.

	logic [3:0] interrupt_enable_mask;
	logic [4:0] modem_control_outputs;
	logic       loop;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			interrupt_enable_mask <= `UIMC_IEM_RESET;
		end else if (wr_iem) begin
			interrupt_enable_mask <= wdata[3:0];
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			modem_control_outputs <= `UIMC_MCO_RESET;
		end else if (wr_mco) begin
			modem_control_outputs <= wdata[4:0];
		end
	end

	assign loop = modem_control_outputs[`UIMC_MCO_LOOP];

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.

	logic [4:0]  pins_sync;
	logic        rx_sync;
	uimc_modem_t mdm_pins;
	uimc_modem_t mdm_now;
	uimc_modem_t mdm_prev;

	uimc_sync2 u_sync (
		.mclk    (mclk),
		.rst     (rst),
		.async   ({serial_rx_pin, carrier_detect_in_n, ring_in_n, data_set_ready_n, clear_send_n}),
		.sync    (pins_sync)
	);

	assign rx_sync  = pins_sync[4];
	assign mdm_pins = ~pins_sync[3:0];

	// Loopback swaps the pins for the control bits.
	always_comb begin
		if (loop) begin
			mdm_now.cts = modem_control_outputs[`UIMC_MCO_RTS];
			mdm_now.dsr = modem_control_outputs[`UIMC_MCO_DTR];
			mdm_now.ring    = modem_control_outputs[`UIMC_MCO_AUX1];
			mdm_now.carrier = modem_control_outputs[`UIMC_MCO_AUX2];
		end else begin
			mdm_now = mdm_pins;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Modem status change flags.

	logic [3:0] msr_delta;
	logic [3:0] next_delta_events;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mdm_prev <= 4'h0;
		end else begin
			mdm_prev <= mdm_now;
		end
	end

	always_comb begin
		next_delta_events[0] = mdm_now.cts ^ mdm_prev.cts;
		next_delta_events[1] = mdm_now.dsr ^ mdm_prev.dsr;
		next_delta_events[2] = mdm_prev.ring & ~mdm_now.ring;
		next_delta_events[3] = mdm_now.carrier ^ mdm_prev.carrier;
	end

	// A change in the cycle of the status read still sets its flag.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			msr_delta <= 4'h0;
		end else begin
			msr_delta <= (rd_msr ? 4'h0 : msr_delta) | next_delta_events;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt sources.

	logic       rls_flag;
	logic       thre_flag;
	logic       thre_prev;
	logic       tmo;
	uimc_code_t code;
	uimc_code_t next_code;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rls_flag <= 1'b0;
		end else begin
			rls_flag <= (rls_flag && !rd_line) || rx_error_event;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			thre_prev <= 1'b0;
		end else begin
			thre_prev <= tx_holding_empty;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			thre_flag <= 1'b0;
		end else begin
			thre_flag <= (thre_flag && !wr_thr && !(rd_isc && code == CODE_THRE))
				|| (tx_holding_empty && !thre_prev);
		end
	end

	uimc_timeout u_timeout (
		.mclk      (mclk),
		.rst       (rst),
		.enable    (buffered_mode_enable),
		.not_empty (rx_not_empty),
		.activity  (rx_fill_change || rd_rbr),
		.char_tick (char_time_tick),
		.timeout   (tmo)
	);

	////////////////////////////////////////////////////////////////////////////
	// Prioritisation.

	always_comb begin
		if (interrupt_enable_mask[`UIMC_IEM_RLS] && rls_flag) begin
			next_code = CODE_RLS;
		end else if (interrupt_enable_mask[`UIMC_IEM_RDA] && rx_data_avail) begin
			next_code = CODE_RDA;
		end else if (interrupt_enable_mask[`UIMC_IEM_RDA] && tmo && buffered_mode_enable) begin
			next_code = CODE_TMO;
		end else if (interrupt_enable_mask[`UIMC_IEM_THRE] && thre_flag) begin
			next_code = CODE_THRE;
		end else if (interrupt_enable_mask[`UIMC_IEM_MSI] && (|msr_delta)) begin
			next_code = CODE_MODEM;
		end else begin
			next_code = CODE_NONE;
		end
	end

	// The reported code and the output hold for the read cycle.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			code <= CODE_NONE;
		end else if (!rd_isc) begin
			code <= next_code;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq_out <= 1'b0;
		end else if (!rd_isc) begin
			irq_out <= next_code != CODE_NONE;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data.

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdata <= 8'h00;
		end else if (rd) begin
			case (addr)
				`UIMC_OFS_IEM: begin
					rdata <= {4'h0, interrupt_enable_mask};
				end
				`UIMC_OFS_ISC: begin
					rdata <= {{2{buffered_mode_enable}}, 2'b00, code[3] && buffered_mode_enable, code[2:0]};
				end
				`UIMC_OFS_MCO: begin
					rdata <= {3'h0, modem_control_outputs};
				end
				`UIMC_OFS_MSR: begin
					rdata <= {mdm_now, msr_delta};
				end
				default: begin
					rdata <= 8'h00;
				end
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pins.

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			terminal_ready_n <= 1'b1;
			request_send_n   <= 1'b1;
		end else begin
			terminal_ready_n <= loop || !modem_control_outputs[`UIMC_MCO_DTR];
			request_send_n   <= loop || !modem_control_outputs[`UIMC_MCO_RTS];
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			aux2_pin_n <= 1'b1;
		end else begin
			case (mf_select)
				`UIMC_MF_AUX2: begin
					aux2_pin_n <= loop || !modem_control_outputs[`UIMC_MCO_AUX2];
				end
				`UIMC_MF_BAUD: begin
					aux2_pin_n <= baud_clock_out;
				end
				`UIMC_MF_RXREQ: begin
					aux2_pin_n <= rx_dma_request_n;
				end
				default: begin
					aux2_pin_n <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			serial_tx_pin <= 1'b1;
			rx_shift_in   <= 1'b1;
		end else begin
			serial_tx_pin <= loop || tx_shift_out;
			rx_shift_in   <= loop ? tx_shift_out : rx_sync;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	property p_rls_first;
		interrupt_enable_mask[`UIMC_IEM_RLS] && rls_flag && !rd_isc |=> code == CODE_RLS;
	endproperty
	a_rls_first: assert property (p_rls_first) else $error("line status not reported first");

	property p_freeze;
		rd_isc |=> code == $past(code) && irq_out == $past(irq_out);
	endproperty
	a_freeze: assert property (p_freeze) else $error("code changed during identification read");

	property p_pending_bit;
		rd_isc |=> rdata[0] == ($past(code) == CODE_NONE) && rdata[0] == !$past(irq_out);
	endproperty
	a_pending_bit: assert property (p_pending_bit) else $error("pending bit wrong");

	property p_tmo_buffered;
		code == CODE_TMO |-> $past(buffered_mode_enable, 2);
	endproperty
	a_tmo_buffered: assert property (p_tmo_buffered) else $error("timeout code in legacy mode");

	property p_fixed_bits;
		rd_isc |=> rdata[5:4] == 2'b00 && rdata[7:6] == {2{$past(buffered_mode_enable)}};
	endproperty
	a_fixed_bits: assert property (p_fixed_bits) else $error("identification upper bits wrong");

	property p_thre_clear;
		wr_thr && !(tx_holding_empty && !thre_prev) |=> !thre_flag;
	endproperty
	a_thre_clear: assert property (p_thre_clear) else $error("transmit empty not cleared");

	property p_disabled;
		interrupt_enable_mask == 4'h0 ##1 interrupt_enable_mask == 4'h0 && !$past(rd_isc) |-> !irq_out;
	endproperty
	a_disabled: assert property (p_disabled) else $error("interrupt with all sources disabled");

	property p_dtr_inverted;
		!loop |=> terminal_ready_n == !$past(modem_control_outputs[`UIMC_MCO_DTR]);
	endproperty
	a_dtr_inverted: assert property (p_dtr_inverted) else $error("terminal ready polarity wrong");

	property p_loop_pins;
		loop |=> serial_tx_pin && terminal_ready_n && request_send_n && rx_shift_in == $past(tx_shift_out);
	endproperty
	a_loop_pins: assert property (p_loop_pins) else $error("loopback pins wrong");

	property p_loop_status;
		loop && rd_msr |=> rdata[7:4] == {$past(modem_control_outputs[3:2]),
			$past(modem_control_outputs[0]), $past(modem_control_outputs[1])};
	endproperty
	a_loop_status: assert property (p_loop_status) else $error("loopback modem status wrong");

	property p_mco_high;
		hit(rd, addr, `UIMC_OFS_MCO) |=> rdata[7:5] == 3'h0;
	endproperty
	a_mco_high: assert property (p_mco_high) else $error("control upper bits not zero");

	c_thre_read: cover property (rd_isc && code == CODE_THRE);
	c_timeout: cover property (code == CODE_TMO);
	c_loop_modem: cover property (loop && code == CODE_MODEM);
	c_irq_drop: cover property (irq_out ##1 !irq_out);

endmodule

// >>> test/uimc_host.sv
// Purpose: Host processor model that drives the register port of the block.
// Assumes: Each task is entered just after a rising clock edge.
// Notes:   Every access ends just after an edge, so back-to-back accesses leave no gap.
`timescale 1ns/100ps

module uimc_host (
	input  wire logic       mclk,  // System clock.
	input  wire logic [7:0] rdata, // Read data from the block.
	output logic      [2:0] addr,  // Register offset.
	output logic      [7:0] wdata, // Write data.
	output logic            wr,    // Write strobe.
	output logic            rd     // Read strobe.
);
	initial begin
		addr  = 3'h0;
		wdata = 8'h00;
		wr    = 1'b0;
		rd    = 1'b0;
	end

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		#1;
	endtask

	// Read data stand only in the cycle after the strobe, so they are taken there.
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		addr <= a;
		rd   <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
endmodule

// >>> test/testbench.sv
// Purpose: Self-checking testbench of the interrupt and modem control block.
// Assumes: All register accesses go through the host model.
// Notes:   Waits after stimulus cover the source flag, the code register and the pin synchronisers.
`timescale 1ns/100ps
`include "uimc_map.svh"

module testbench import uimc_pkg::*; ;
	localparam logic [2:0] DAT = `UIMC_OFS_DATA;
	localparam logic [2:0] IEM = `UIMC_OFS_IEM;
	localparam logic [2:0] ISC = `UIMC_OFS_ISC;
	localparam logic [2:0] MCO = `UIMC_OFS_MCO;
	localparam logic [2:0] LST = `UIMC_OFS_LINE;
	localparam logic [2:0] MST = `UIMC_OFS_MSR;

	logic       mclk = 1'b0;
	logic       rst  = 1'b1;
	logic [2:0] addr;
	logic [7:0] wdata, rdata;
	logic       wr, rd;
	logic       buffered_mode_enable, rx_error_event, rx_data_avail, rx_not_empty, rx_fill_change;
	logic       char_time_tick, tx_holding_empty, tx_shift_out, serial_rx_pin, baud_clock_out;
	logic       clear_send_n, data_set_ready_n, ring_in_n, carrier_detect_in_n, rx_dma_request_n;
	logic [1:0] mf_select;
	logic       irq_out, serial_tx_pin, rx_shift_in, terminal_ready_n, request_send_n, aux2_pin_n;
	int         n_errors = 0;
	int         n_tests  = 0;
	int         cycles   = 0;

	always #20 mclk = ~mclk;

	uimc_host i_uimc_host (.mclk(mclk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

	uimc_core i_uimc_core (
		.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.buffered_mode_enable(buffered_mode_enable), .rx_error_event(rx_error_event),
		.rx_data_avail(rx_data_avail), .rx_not_empty(rx_not_empty), .rx_fill_change(rx_fill_change),
		.char_time_tick(char_time_tick), .tx_holding_empty(tx_holding_empty), .tx_shift_out(tx_shift_out),
		.serial_rx_pin(serial_rx_pin), .clear_send_n(clear_send_n), .data_set_ready_n(data_set_ready_n),
		.ring_in_n(ring_in_n), .carrier_detect_in_n(carrier_detect_in_n), .mf_select(mf_select),
		.baud_clock_out(baud_clock_out), .rx_dma_request_n(rx_dma_request_n), .irq_out(irq_out),
		.serial_tx_pin(serial_tx_pin), .rx_shift_in(rx_shift_in), .terminal_ready_n(terminal_ready_n),
		.request_send_n(request_send_n), .aux2_pin_n(aux2_pin_n));

	////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			$display("[ERR] %0t run did not finish", $time);
			n_errors++;
			print_verdict();
		end
	end

	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t register read %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_pin(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t output %b expected %b", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic put(input logic [2:0] a, input logic [7:0] d);
		i_uimc_host.wr_reg(a, d);
	endtask

	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
		logic [7:0] d;
		i_uimc_host.rd_reg(a, d);
		chk_reg(d, exp);
	endtask

	task automatic pulse_err();
		rx_error_event <= 1'b1;
		cyc(1);
		rx_error_event <= 1'b0;
	endtask

	task automatic ticks(input int n);
		repeat (n) begin
			char_time_tick <= 1'b1;
			cyc(1);
			char_time_tick <= 1'b0;
			cyc(1);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk_pin(irq_out, 1'b0);
		chk_pin(terminal_ready_n, 1'b1);
		chk_pin(aux2_pin_n, 1'b1);
		rd_chk(ISC, 8'h01);
		rd_chk(MCO, 8'h00);
		put(3'h7, 8'hff);
		rd_chk(3'h7, 8'h00);
		tx_shift_out  <= 1'b0;
		serial_rx_pin <= 1'b0;
		cyc(5);
		chk_pin(serial_tx_pin, 1'b0);
		chk_pin(rx_shift_in, 1'b0);
		$display("reset test done");
	endtask

	task automatic t_pins();
		put(IEM, 8'hff);
		rd_chk(IEM, 8'h0f);
		put(MCO, 8'he6);
		rd_chk(MCO, 8'h06);
		cyc(2);
		chk_pin(terminal_ready_n, 1'b1);
		chk_pin(request_send_n, 1'b0);
		put(MCO, 8'h0b);
		cyc(2);
		chk_pin(terminal_ready_n, 1'b0);
		chk_pin(aux2_pin_n, 1'b0);
		baud_clock_out   <= 1'b1;
		rx_dma_request_n <= 1'b0;
		for (int m = 1; m < 4; m++) begin
			mf_select <= m[1:0];
			cyc(3);
			chk_pin(aux2_pin_n, m != 2);
		end
		mf_select <= 2'h0;
		$display("pin test done");
	endtask

	task automatic t_prio();
		tx_holding_empty <= 1'b1;
		cyc(3);
		chk_pin(irq_out, 1'b1);
		rx_data_avail <= 1'b1;
		cyc(3);
		rd_chk(ISC, {4'h0, CODE_RDA});
		pulse_err();
		cyc(3);
		rd_chk(ISC, {4'h0, CODE_RLS});
		rd_chk(LST, 8'h00);
		cyc(3);
		rd_chk(ISC, {4'h0, CODE_RDA});
		rx_data_avail <= 1'b0;
		cyc(3);
		rd_chk(ISC, {4'h0, CODE_THRE});
		cyc(3);
		chk_pin(irq_out, 1'b0);
		tx_holding_empty <= 1'b0;
		cyc(1);
		tx_holding_empty <= 1'b1;
		cyc(3);
		put(DAT, 8'h55);
		cyc(3);
		buffered_mode_enable <= 1'b1;
		rd_chk(ISC, 8'hc1);
		buffered_mode_enable <= 1'b0;
		$display("priority test done");
	endtask

	task automatic t_freeze();
		rx_error_event <= 1'b1;
		cyc(1);
		rx_error_event <= 1'b0;
		rd_chk(ISC, 8'h01);
		chk_pin(irq_out, 1'b0);
		cyc(1);
		chk_pin(irq_out, 1'b1);
		rd_chk(ISC, {4'h0, CODE_RLS});
		rd_chk(LST, 8'h00);
		cyc(3);
		$display("freeze test done");
	endtask

	task automatic t_timeout();
		put(IEM, 8'h01);
		buffered_mode_enable <= 1'b1;
		rx_not_empty         <= 1'b1;
		cyc(2);
		ticks(3);
		cyc(3);
		chk_pin(irq_out, 1'b0);
		rx_fill_change <= 1'b1;
		cyc(1);
		rx_fill_change <= 1'b0;
		ticks(3);
		cyc(3);
		chk_pin(irq_out, 1'b0);
		ticks(1);
		cyc(3);
		rd_chk(ISC, {4'hc, CODE_TMO});
		rd_chk(DAT, 8'h00);
		cyc(3);
		rd_chk(ISC, 8'hc1);
		buffered_mode_enable <= 1'b0;
		cyc(2);
		ticks(5);
		cyc(3);
		rd_chk(ISC, 8'h01);
		rx_not_empty <= 1'b0;
		$display("timeout test done");
	endtask

	task automatic t_loop();
		put(MCO, 8'h10);
		put(IEM, 8'h08);
		tx_shift_out  <= 1'b0;
		serial_rx_pin <= 1'b1;
		cyc(4);
		chk_pin(serial_tx_pin, 1'b1);
		chk_pin(rx_shift_in, 1'b0);
		rd_chk(ISC, 8'h01);
		put(MCO, 8'h1f);
		cyc(4);
		chk_pin(irq_out, 1'b1);
		chk_pin(terminal_ready_n, 1'b1);
		chk_pin(request_send_n, 1'b1);
		chk_pin(aux2_pin_n, 1'b1);
		rd_chk(ISC, {4'h0, CODE_MODEM});
		rd_chk(MST, 8'hfb);
		cyc(3);
		rd_chk(ISC, 8'h01);
		put(MCO, 8'h1b);
		cyc(4);
		rd_chk(MST, 8'hb4);
		put(IEM, 8'h00);
		put(MCO, 8'h1e);
		cyc(4);
		chk_pin(irq_out, 1'b0);
		rd_chk(MST, 8'hd2);
		put(MCO, 8'h00);
		cyc(4);
		rd_chk(MST, 8'h0d);
		tx_shift_out <= 1'b1;
		$display("loopback test done");
	endtask

	task automatic t_mask();
		put(IEM, 8'h02);
		pulse_err();
		rx_data_avail <= 1'b1;
		clear_send_n  <= 1'b0;
		cyc(6);
		chk_pin(irq_out, 1'b0);
		rd_chk(MST, 8'h11);
		rd_chk(ISC, 8'h01);
		tx_holding_empty <= 1'b0;
		cyc(1);
		tx_holding_empty <= 1'b1;
		cyc(3);
		rd_chk(ISC, {4'h0, CODE_THRE});
		$display("mask test done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		buffered_mode_enable = 1'b0;
		rx_error_event       = 1'b0;
		rx_data_avail        = 1'b0;
		rx_not_empty         = 1'b0;
		rx_fill_change       = 1'b0;
		char_time_tick       = 1'b0;
		tx_holding_empty     = 1'b0;
		tx_shift_out         = 1'b1;
		serial_rx_pin        = 1'b1;
		clear_send_n         = 1'b1;
		data_set_ready_n     = 1'b1;
		ring_in_n            = 1'b1;
		carrier_detect_in_n  = 1'b1;
		mf_select            = 2'h0;
		baud_clock_out       = 1'b0;
		rx_dma_request_n     = 1'b1;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		cyc(1);
		t_reset();
		t_pins();
		t_prio();
		t_freeze();
		t_timeout();
		t_loop();
		t_mask();
		print_verdict();
	end
endmodule
